//--- billboard_fallback_pkg.sv
// Constants, register map and state encoding of the billboard fallback sequencer.
// Assumes one 10 MHz core clock and a 32-bit APB slave port.
package billboard_fallback_pkg;

  // Clock and tick timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // Forced detach lasts this many ticks (100 ms)
  localparam int unsigned DETACH_HOLD_TICKS = 10;

  ////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam int unsigned ADDR_W = 18;
  localparam logic [15:0] IDX_ADDR_TMO_LOW = 16'h413c;
  localparam logic [15:0] IDX_ADDR_TMO_HIGH = 16'h413d;
  localparam logic [15:0] IDX_STR_TMO_LOW = 16'h413e;
  localparam logic [15:0] IDX_STR_TMO_HIGH = 16'h413f;
  localparam logic [15:0] IDX_CONTROL = 16'h4140;
  localparam logic [15:0] IDX_STATUS = 16'h4141;

  // Reset values
  localparam logic [7:0] TMO_LOW_RST = 8'hd0;
  localparam logic [7:0] TMO_HIGH_RST = 8'h07;
  localparam logic [7:0] CONTROL_RST = 8'h14;

  // Control fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_SEL_LSB = 1;
  localparam int unsigned CTRL_SEL_MSB = 5;
  localparam logic [4:0] SEL_DEFAULT = 5'h0a;
  localparam logic [4:0] SEL_RESERVED = 5'h09;

  // Pins and descriptor constants
  localparam int unsigned GPIO_W = 72;
  localparam logic [6:0] DEFAULT_REQUEST_PIN = 7'h44;
  localparam logic [1:0] CFG_UNSPECIFIED = 2'h0;
  localparam logic [15:0] BB_CLASS_VERSION = 16'h0110;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_NORMAL = 4'h1,
    ST_DETACH_BB = 4'h2,
    ST_BILLBOARD = 4'h4,
    ST_DETACH_STD = 4'h8
  } seq_state_type;

endpackage

//--- billboard_fallback_ctrl.sv
// Billboard fallback sequencer: swaps the internal function device into a
// billboard device on a low request pin and back again on timer expiry.
// Assumes address and string events are one-cycle pulses on clk_sys_i.
// Summary of operation
// - Request pin picked by 5-bit select
// - Reset select uses default request pin
// - Request pin is active low
// - Control bit 0 enables the feature
// - Low request first forces a detach
// - Then reattach with billboard descriptors
// - Address assignment starts first timer
// - Configured status reports unspecified error
// - String request starts second timer
// - Timer expiry forces a detach
// - Then reattach with standard descriptors
// - Timeout is 16-bit high and low
// - One count equals 10 ms
`timescale 1ns/100ps
module billboard_fallback_ctrl #(
  parameter int unsigned TICK_CYCLES = billboard_fallback_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [billboard_fallback_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // General-purpose pins, indexed by pin number
  input wire logic [billboard_fallback_pkg::GPIO_W-1:0] gpio_i,
  // Hub core events
  input wire logic addr_assigned_i,
  input wire logic alt_string_req_i,
  // Function device control
  output logic func_attach_o,
  output logic billboard_desc_o,
  output logic [1:0] bb_configured_o,
  output logic [15:0] bb_version_o
);
  import billboard_fallback_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] tmo_lo_r [2];
  logic [7:0] tmo_hi_r [2];
  logic [5:0] ctrl_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [GPIO_W-1:0] gpio_s1_r;
  logic [GPIO_W-1:0] gpio_s2_r;
  logic armed_r;
  logic [31:0] presc_r;
  logic [7:0] hold_r;
  logic [1:0] run_r;
  logic [15:0] tcnt_r [2];
  logic attach_r;
  logic bbdesc_r;
  logic req_n;
  seq_state_type state_r;
  seq_state_type state_nxt;

  // Maps a select code to {valid, pin number}
  function automatic logic [7:0] pin_of(input logic [4:0] code);
    case (code)
      5'h00: pin_of = {1'b1, 7'd64};
      5'h01: pin_of = {1'b1, 7'd1};
      5'h02: pin_of = {1'b1, 7'd2};
      5'h03: pin_of = {1'b1, 7'd3};
      5'h04: pin_of = {1'b1, 7'd65};
      5'h05: pin_of = {1'b1, 7'd66};
      5'h06: pin_of = {1'b1, 7'd67};
      5'h07: pin_of = {1'b1, 7'd23};
      5'h08: pin_of = {1'b1, 7'd10};
      5'h0a: pin_of = {1'b1, DEFAULT_REQUEST_PIN};
      5'h0b: pin_of = {1'b1, 7'd6};
      5'h0c: pin_of = {1'b1, 7'd69};
      5'h0d: pin_of = {1'b1, 7'd70};
      5'h0e: pin_of = {1'b1, 7'd71};
      5'h0f: pin_of = {1'b1, 7'd5};
      5'h10: pin_of = {1'b1, 7'd4};
      default: pin_of = 8'h00;
    endcase
  endfunction

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  wire setup = psel_i & ~penable_i;
  wire wr_en = psel_i & penable_i & pwrite_i & pstrb_i[0];
  wire hit_alo = paddr_i == byte_addr(IDX_ADDR_TMO_LOW);
  wire hit_ahi = paddr_i == byte_addr(IDX_ADDR_TMO_HIGH);
  wire hit_blo = paddr_i == byte_addr(IDX_STR_TMO_LOW);
  wire hit_bhi = paddr_i == byte_addr(IDX_STR_TMO_HIGH);
  wire hit_ctl = paddr_i == byte_addr(IDX_CONTROL);
  wire hit_sts = paddr_i == byte_addr(IDX_STATUS);
  wire mapped = hit_alo | hit_ahi | hit_blo | hit_bhi | hit_ctl | hit_sts;
  wire enabled = ctrl_r[CTRL_EN_BIT];
  wire [4:0] sel = ctrl_r[CTRL_SEL_MSB:CTRL_SEL_LSB];
  wire [7:0] status_val = {state_r, run_r, armed_r, req_n};
  wire [7:0] ctrl_val = {2'b00, ctrl_r};
  wire [7:0] rd_val =
    hit_alo ? tmo_lo_r[0] :
    hit_ahi ? tmo_hi_r[0] :
    hit_blo ? tmo_lo_r[1] :
    hit_bhi ? tmo_hi_r[1] :
    hit_ctl ? ctrl_val :
    hit_sts ? status_val : 8'h00;

  // Zero wait states keeps the bus slave trivial
  assign pready_o = 1'b1;
  assign prdata_o = prdata_r;
  assign pslverr_o = pslverr_r;

  // Read data and error are latched in the setup cycle
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= {24'h00_0000, rd_val};
      pslverr_r <= ~mapped;
    end
  end

  // Register writes, low byte lane only
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tmo_lo_r[0] <= TMO_LOW_RST;
      tmo_hi_r[0] <= TMO_HIGH_RST;
      tmo_lo_r[1] <= TMO_LOW_RST;
      tmo_hi_r[1] <= TMO_HIGH_RST;
      ctrl_r <= CONTROL_RST[5:0];
    end else if (wr_en) begin
      if (hit_alo) tmo_lo_r[0] <= pwdata_i[7:0];
      if (hit_ahi) tmo_hi_r[0] <= pwdata_i[7:0];
      if (hit_blo) tmo_lo_r[1] <= pwdata_i[7:0];
      if (hit_bhi) tmo_hi_r[1] <= pwdata_i[7:0];
      if (hit_ctl) ctrl_r <= pwdata_i[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; pins are asynchronous to the core clock
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      gpio_s1_r <= '1;
      gpio_s2_r <= '1;
    end else begin
      gpio_s1_r <= gpio_i;
      gpio_s2_r <= gpio_s1_r;
    end
  end

  wire [7:0] pin_sel = pin_of(sel);
  assign req_n = pin_sel[7] ? gpio_s2_r[pin_sel[6:0]] : 1'b1;
  wire trigger = enabled & ~req_n & armed_r & (state_r == ST_NORMAL);

  // Re-arm only after the pin goes high, so a pin held low does not loop
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) armed_r <= 1'b1;
    else if (trigger) armed_r <= 1'b0;
    else if (req_n) armed_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // 10 ms tick
  // Free-running, so the first tick after a start may come early by < 10 ms
  wire tick = presc_r == TICK_CYCLES - 1;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) presc_r <= 32'h0000_0000;
    else presc_r <= tick ? 32'h0000_0000 : presc_r + 32'h0000_0001;
  end

  // Detach hold counter, cleared on each state change
  wire in_detach = (state_r == ST_DETACH_BB) | (state_r == ST_DETACH_STD);
  wire hold_done = hold_r == DETACH_HOLD_TICKS[7:0];
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) hold_r <= 8'h00;
    else if (state_nxt != state_r) hold_r <= 8'h00;
    else if (in_detach && tick && !hold_done) hold_r <= hold_r + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // Detach timers: index 0 on address set, index 1 on string request
  wire in_bb = state_r == ST_BILLBOARD;
  wire [1:0] start = {alt_string_req_i, addr_assigned_i} & {2{in_bb}} & ~run_r;
  wire [15:0] lim_a = {tmo_hi_r[0], tmo_lo_r[0]};
  wire [15:0] lim_b = {tmo_hi_r[1], tmo_lo_r[1]};
  wire [1:0] expired = run_r & {tcnt_r[1] == lim_b, tcnt_r[0] == lim_a};
  wire expire_any = |expired;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      run_r <= 2'b00;
      for (int i = 0; i < 2; i++) tcnt_r[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!in_bb) begin
          run_r[i] <= 1'b0;
        end else if (start[i]) begin
          run_r[i] <= 1'b1;
          tcnt_r[i] <= 16'h0000;
        end else if (run_r[i] && tick && !expired[i]) begin
          tcnt_r[i] <= tcnt_r[i] + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_NORMAL: if (trigger) state_nxt = ST_DETACH_BB;
      ST_DETACH_BB: begin
        if (!enabled) state_nxt = ST_DETACH_STD;
        else if (hold_done) state_nxt = ST_BILLBOARD;
      end
      ST_BILLBOARD: if (expire_any || !enabled) state_nxt = ST_DETACH_STD;
      ST_DETACH_STD: if (hold_done) state_nxt = ST_NORMAL;
      default: state_nxt = ST_NORMAL;
    endcase
  end

  // State and attach outputs registered together
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= ST_NORMAL;
      attach_r <= 1'b1;
      bbdesc_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      attach_r <= (state_nxt == ST_NORMAL) | (state_nxt == ST_BILLBOARD);
      bbdesc_r <= state_nxt == ST_BILLBOARD;
    end
  end

  assign func_attach_o = attach_r;
  assign billboard_desc_o = bbdesc_r;
  assign bb_configured_o = CFG_UNSPECIFIED;
  assign bb_version_o = BB_CLASS_VERSION;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  chk_ctrl_reserved: assert property (
    psel_i && penable_i && !pwrite_i && hit_ctl |-> prdata_o[7:6] == 2'b00)
    else $error("control reserved bits not zero");
  chk_default_pin: assert property (
    sel == SEL_DEFAULT |-> req_n == gpio_s2_r[68])
    else $error("default select not on default pin");
  chk_reserved_sel: assert property (
    sel == SEL_RESERVED |-> req_n)
    else $error("reserved select code acted as a pin");
  chk_low_detach: assert property (
    enabled && !req_n && armed_r && state_r == ST_NORMAL
    |=> !func_attach_o && state_r == ST_DETACH_BB)
    else $error("low request did not force detach");
  chk_disabled_idle: assert property (
    !enabled && state_r == ST_NORMAL |=> state_r == ST_NORMAL && func_attach_o)
    else $error("sequencer left idle while disabled");
  chk_bb_attach: assert property (
    state_r == ST_DETACH_BB && hold_done && enabled
    |=> func_attach_o && billboard_desc_o && bb_version_o == 16'h0110)
    else $error("billboard reattach wrong");
  chk_timer_a_go: assert property (
    in_bb && addr_assigned_i && !run_r[0] && enabled && !expire_any
    |=> run_r[0] && tcnt_r[0] == 16'h0000)
    else $error("address timer did not start");
  chk_timer_b_go: assert property (
    in_bb && alt_string_req_i && !run_r[1] && enabled && !expire_any
    |=> run_r[1] && tcnt_r[1] == 16'h0000)
    else $error("string timer did not start");
  chk_cfg_status: assert property (
    billboard_desc_o |-> bb_configured_o == 2'b00)
    else $error("configured status not unspecified");
  chk_expire_detach: assert property (
    in_bb && expire_any |=> !func_attach_o ##1 !billboard_desc_o)
    else $error("expiry did not detach");
  chk_std_attach: assert property (
    state_r == ST_DETACH_STD && hold_done |=> func_attach_o && !billboard_desc_o)
    else $error("standard reattach wrong");
  chk_no_early_exp: assert property (
    in_bb && enabled && run_r[0] && tcnt_r[0] < lim_a && !run_r[1]
    |=> state_r == ST_BILLBOARD)
    else $error("timer expired before its count");
  chk_tick_step: assert property (
    run_r[0] && in_bb && !tick && !start[0] |=> $stable(tcnt_r[0]))
    else $error("timer moved without a tick");

  cov_trigger: cover property (trigger ##1 state_r == ST_DETACH_BB);
  cov_exp_a: cover property (in_bb && expired[0]);
  cov_exp_b: cover property (in_bb && expired[1]);
  cov_back_normal: cover property (state_r == ST_DETACH_STD ##1 state_r == ST_NORMAL);

endmodule // billboard_fallback_ctrl

//--- billboard_pd_model.sv
// Far-side model: power delivery controller pulling one request pin low.
// Assumes the pins it does not drive are pulled up on the board.
`timescale 1ns/100ps
module billboard_pd_model (
  // Commands from the bench
  input wire logic fail_i,
  input wire logic [6:0] pin_i,
  // Pins seen by the hub
  output logic [71:0] gpio_o
);
  // failure pulls pin low
  // Undriven pins sit at the pull-up level, never at a stale value
  assign gpio_o = fail_i ? ~(72'h1 << pin_i) : {72{1'b1}};
endmodule // billboard_pd_model

//--- tb_billboard_fallback_ctrl.sv
// Testbench of the billboard fallback sequencer: APB tasks and sequences.
// Assumes TICK_CYCLES of 10, so one timer count lasts 10 clocks.
`timescale 1ns/100ps
module tb_billboard_fallback_ctrl;
  import billboard_fallback_pkg::*;
  localparam int TICK = 10;
  logic clk_sys_i, reset_i, psel, penable, pwrite, fail, addr_ev, str_ev;
  logic pready, pslverr, attach, bb_desc, rerr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] pstrb;
  logic [1:0] cfg;
  logic [15:0] ver;
  logic [6:0] pin;
  logic [GPIO_W-1:0] gpio;
  int num_errors, compares, n;

  ////////////////////////////////////////////////////////////////////////
  // Design and far-side model
  billboard_fallback_ctrl #(.TICK_CYCLES(TICK)) dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .gpio_i(gpio),
    .addr_assigned_i(addr_ev), .alt_string_req_i(str_ev), .func_attach_o(attach),
    .billboard_desc_o(bb_desc), .bb_configured_o(cfg), .bb_version_o(ver));
  billboard_pd_model pd (.fail_i(fail), .pin_i(pin), .gpio_o(gpio));

  // Clock at 10 MHz
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict and comparisons
  task test_done;
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task check_rng(input int v, input int lo, input int hi);
    check({31'h0, (v >= lo && v <= hi)}, 32'h1);
  endtask

  // One APB transfer; the request is held until pready is seen high
  task apb(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
    int k;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) num_errors++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [15:0] idx, input logic [31:0] exp, input logic err);
    apb(idx, 1'b0, 8'h00);
    check(rdata, exp);
    check({31'h0, rerr}, {31'h0, err});
  endtask

  // Counts clocks until the attach output reaches a level
  task wait_att(input logic v);
    n = 0;
    while (attach !== v && n < 4000) begin
      @(posedge clk_sys_i);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Sequences
  task enter_bb(input logic [6:0] p);
    @(posedge clk_sys_i);
    pin <= p;
    fail <= 1'b1;
    wait_att(1'b0);
    check_rng(n, 1, 6);
    fail <= 1'b0;
    wait_att(1'b1);
    check_rng(n, 85, 110);
    check({31'h0, bb_desc}, 32'h1);
  endtask

  // Timer start event, then expiry detach and standard reattach
  task leave_bb(input logic use_addr, input int lim);
    @(posedge clk_sys_i);
    addr_ev <= use_addr;
    str_ev <= ~use_addr;
    @(posedge clk_sys_i);
    addr_ev <= 1'b0;
    str_ev <= 1'b0;
    wait_att(1'b0);
    check_rng(n, (lim - 1) * TICK - 2, lim * TICK + 6);
    wait_att(1'b1);
    check_rng(n, 85, 110);
    check({31'h0, bb_desc}, 32'h0);
  endtask

  initial begin
    reset_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    fail = 1'b0;
    pin = 7'h44;
    addr_ev = 1'b0;
    str_ev = 1'b0;
    num_errors = 0;
    compares = 0;
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(IDX_ADDR_TMO_LOW, 32'hd0, 1'b0);
    rd(IDX_ADDR_TMO_HIGH, 32'h07, 1'b0);
    rd(IDX_STR_TMO_LOW, 32'hd0, 1'b0);
    rd(IDX_STR_TMO_HIGH, 32'h07, 1'b0);
    rd(IDX_STATUS, 32'h13, 1'b0);
    rd(IDX_CONTROL, 32'h14, 1'b0);
    rd(16'h4150, 32'h0, 1'b1);
    check({30'h0, cfg}, 32'h0);
    check({16'h0, ver}, 32'h0110);
    apb(IDX_CONTROL, 1'b1, 8'hff);
    rd(IDX_CONTROL, 32'h3f, 1'b0);
    // Write without the low byte strobe must not land
    pstrb <= 4'he;
    apb(IDX_ADDR_TMO_LOW, 1'b1, 8'h55);
    pstrb <= 4'hf;
    rd(IDX_ADDR_TMO_LOW, 32'hd0, 1'b0);
    apb(IDX_CONTROL, 1'b1, 8'h14);
    fail <= 1'b1;
    repeat (30) @(posedge clk_sys_i);
    check({31'h0, attach}, 32'h1);
    apb(IDX_CONTROL, 1'b1, 8'h13);
    repeat (30) @(posedge clk_sys_i);
    check({31'h0, attach}, 32'h1);
    fail <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    apb(IDX_CONTROL, 1'b1, 8'h15);
    apb(IDX_ADDR_TMO_LOW, 1'b1, 8'h02);
    apb(IDX_ADDR_TMO_HIGH, 1'b1, 8'h01);
    enter_bb(7'h44);
    leave_bb(1'b1, 258);
    apb(IDX_CONTROL, 1'b1, 8'h07);
    apb(IDX_STR_TMO_LOW, 1'b1, 8'h04);
    apb(IDX_STR_TMO_HIGH, 1'b1, 8'h00);
    enter_bb(7'h03);
    leave_bb(1'b0, 4);
    // disable while in billboard returns to standard
    enter_bb(7'h03);
    apb(IDX_CONTROL, 1'b1, 8'h06);
    wait_att(1'b0);
    check_rng(n, 1, 6);
    wait_att(1'b1);
    check_rng(n, 85, 110);
    check({31'h0, bb_desc}, 32'h0);
    test_done;
  end

  // Watchdog well beyond the roughly 3400 clocks the sequences need
  initial begin
    #1000000;
    num_errors++;
    test_done;
  end
endmodule // tb_billboard_fallback_ctrl
